// [low_freq_clock_common.sv]
// Shared constants for the slow clock selector and its pin input filter.
// Notes on behaviour
// - Reset leaves RC oscillator on and selected.
// - Crystal oscillator stays off until software asks.
// - Select runs: pins, crystal on, RC off.
// - Switch to crystal never shortens a clock phase.
// - Crystal choice sticks until io supply drops.
// - Reset leaves crystal pins as pulled-up inputs.
`timescale 1ns/1ps

package lfclk_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned PIN_SETTLE_NS = 1000;
	localparam int unsigned PIN_SETTLE_CYC =
		(PIN_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned XTAL_START_US = 1000;
	localparam int unsigned XTAL_START_CYC = XTAL_START_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W          = 32;
	localparam logic        SYNC_RST_VAL   = 1'b0;
	localparam logic        SUPPLY_RST_VAL = 1'b1;

	typedef enum logic [2:0] {
		ST_RC,
		ST_PINS,
		ST_OSC_START,
		ST_WAIT_LOW,
		ST_WAIT_FALL,
		ST_XTAL
	} sel_state_t;
endpackage

// Three-stage pin filter: output follows once stages two and three agree.
module pin_filter
	import lfclk_pkg::*;
#(
	parameter logic RST_VAL = SYNC_RST_VAL
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      level
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	always_comb begin
		stage_d = {stage_q[1:0], pin};
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage_q <= {3{RST_VAL}};
			level_q <= RST_VAL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule

// [slow_clock_source_select.sv]
// Slow clock source selector: RC by default, one-way switch to crystal.
`timescale 1ns/1ps

module slow_clock_source_select
	import lfclk_pkg::*;
#(
	parameter int unsigned XTAL_START = XTAL_START_CYC,
	parameter int unsigned PIN_SETTLE = PIN_SETTLE_CYC
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic crystal_select_wr,
	input  wire logic crystal_select_bit,
	input  wire logic crystal_bypass_bit,
	input  wire logic io_supply_ok,
	input  wire logic rc_clk_in,
	input  wire logic crystal_in_pin,
	output logic      low_freq_clock,
	output logic      rc_osc_en,
	output logic      xtal_osc_en,
	output logic      xtal_bypass_en,
	output logic      pins_to_osc,
	output logic      pin_pullup_en,
	output logic      xtal_select_state,
	output logic      xtal_active,
	output logic      switch_busy
);
	logic rc_lvl;
	logic xtal_lvl;
	logic supply_lvl;

	pin_filter #(.RST_VAL(SYNC_RST_VAL)) u_rc_filt (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (rc_clk_in),
		.level (rc_lvl)
	);

	pin_filter #(.RST_VAL(SYNC_RST_VAL)) u_xtal_filt (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (crystal_in_pin),
		.level (xtal_lvl)
	);

	pin_filter #(.RST_VAL(SUPPLY_RST_VAL)) u_supply_filt (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (io_supply_ok),
		.level (supply_lvl)
	);

	sel_state_t       state_q;
	sel_state_t       state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             sel_q;
	logic             sel_d;
	logic             bypass_q;
	logic             bypass_d;
	logic             rc_en_q;
	logic             rc_en_d;
	logic             xtal_en_q;
	logic             xtal_en_d;
	logic             pins_q;
	logic             pins_d;
	logic             use_xtal_q;
	logic             use_xtal_d;
	logic             xtal_prev_q;
	logic             xtal_prev_d;
	logic             clk_out_q;
	logic             clk_out_d;
	logic             busy_q;
	logic             busy_d;
	logic             pullup_q;
	logic             pullup_d;
	logic             byp_en_q;
	logic             byp_en_d;
	logic             xtal_fall;

	assign xtal_fall = xtal_prev_q & ~xtal_lvl;

	// Sequencer and sticky select
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		sel_d       = sel_q;
		bypass_d    = bypass_q;
		rc_en_d     = rc_en_q;
		xtal_en_d   = xtal_en_q;
		pins_d      = pins_q;
		use_xtal_d  = use_xtal_q;
		busy_d      = busy_q;
		// Writes of zero are ignored
		if (crystal_select_wr && crystal_select_bit) begin
			sel_d = 1'b1;
		end
		case (state_q)
			ST_RC: begin
				if (sel_d && !sel_q) begin
					// Bypass choice is taken as it stands at the select write
					bypass_d = crystal_bypass_bit;
					pins_d   = 1'b1;
					cnt_d    = CNT_W'(PIN_SETTLE);
					busy_d   = 1'b1;
					state_d  = ST_PINS;
				end
			end
			ST_PINS: begin
				if (cnt_q <= CNT_W'(1)) begin
					xtal_en_d = 1'b1;
					cnt_d     = CNT_W'(XTAL_START);
					state_d   = ST_OSC_START;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			ST_OSC_START: begin
				if (cnt_q <= CNT_W'(1)) begin
					state_d = ST_WAIT_LOW;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			ST_WAIT_LOW: begin
				// Let the RC high phase finish before anything moves
				if (!clk_out_q) begin
					state_d = ST_WAIT_FALL;
				end
			end
			ST_WAIT_FALL: begin
				// Hand over on a crystal falling edge: low only stretches
				if (xtal_fall) begin
					use_xtal_d = 1'b1;
					rc_en_d    = 1'b0;
					busy_d     = 1'b0;
					state_d    = ST_XTAL;
				end
			end
			ST_XTAL: begin
				state_d = ST_XTAL;
			end
			default: begin
				state_d = ST_RC;
			end
		endcase
		// Loss of io supply is the only way back to RC
		if (!supply_lvl) begin
			state_d    = ST_RC;
			sel_d      = 1'b0;
			bypass_d   = 1'b0;
			rc_en_d    = 1'b1;
			xtal_en_d  = 1'b0;
			pins_d     = 1'b0;
			use_xtal_d = 1'b0;
			busy_d     = 1'b0;
			cnt_d      = '0;
		end
		// Pin status outputs registered so every port comes from a flop
		pullup_d = ~pins_d;
		byp_en_d = bypass_d & pins_d;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_RC;
			cnt_q      <= '0;
			sel_q      <= 1'b0;
			bypass_q   <= 1'b0;
			rc_en_q    <= 1'b1;
			xtal_en_q  <= 1'b0;
			pins_q     <= 1'b0;
			use_xtal_q <= 1'b0;
			busy_q     <= 1'b0;
			pullup_q   <= 1'b1;
			byp_en_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			sel_q      <= sel_d;
			bypass_q   <= bypass_d;
			rc_en_q    <= rc_en_d;
			xtal_en_q  <= xtal_en_d;
			pins_q     <= pins_d;
			use_xtal_q <= use_xtal_d;
			busy_q     <= busy_d;
			pullup_q   <= pullup_d;
			byp_en_q   <= byp_en_d;
		end
	end

	// Clock output mux
	always_comb begin
		xtal_prev_d = xtal_lvl;
		clk_out_d   = clk_out_q;
		if (use_xtal_d) begin
			clk_out_d = xtal_lvl;
		end else if (state_q == ST_WAIT_FALL || state_d == ST_WAIT_FALL) begin
			clk_out_d = 1'b0;
		end else if (rc_en_q) begin
			clk_out_d = rc_lvl;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xtal_prev_q <= 1'b0;
			clk_out_q   <= 1'b0;
		end else begin
			xtal_prev_q <= xtal_prev_d;
			clk_out_q   <= clk_out_d;
		end
	end

	assign low_freq_clock    = clk_out_q;
	assign rc_osc_en         = rc_en_q;
	assign xtal_osc_en       = xtal_en_q;
	assign xtal_bypass_en    = byp_en_q;
	assign pins_to_osc       = pins_q;
	assign pin_pullup_en     = pullup_q;
	assign xtal_select_state = sel_q;
	assign xtal_active       = use_xtal_q;
	assign switch_busy       = busy_q;
endmodule

// [xtal_model.sv]
// Crystal or external clock source on the crystal input pin.
`timescale 1ns/1ps
module xtal_model (
	input  wire logic osc_en,
	input  wire logic byp_en,
	output logic      pin
);
	logic ph = 1'b0;
	always #610 ph = !ph;
	// Idle pin rests at its pull-up level
	assign pin = (osc_en || byp_en) ? ph : 1'b1;
endmodule

// [low_freq_clock_chk.sv]
// Assertion checker for the slow clock source selector.
`timescale 1ns/1ps
module lfclk_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic crystal_select_wr,
	input wire logic crystal_select_bit,
	input wire logic io_supply_ok,
	input wire logic low_freq_clock,
	input wire logic rc_osc_en,
	input wire logic xtal_osc_en,
	input wire logic xtal_bypass_en,
	input wire logic pins_to_osc,
	input wire logic pin_pullup_en,
	input wire logic xtal_select_state,
	input wire logic xtal_active,
	input wire logic switch_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_RC: assert property (!xtal_select_state |-> rc_osc_en && !xtal_active)
		else $error("RC not kept");
	AST_XOFF: assert property (!xtal_select_state |-> !xtal_osc_en)
		else $error("crystal on early");
	AST_PINS: assert property (!xtal_select_state |-> pin_pullup_en && !pins_to_osc)
		else $error("pins not pulled up");
	AST_ORDER: assert property ($rose(xtal_osc_en) |-> pins_to_osc && rc_osc_en)
		else $error("bad enable order");
	AST_ACT: assert property (xtal_active |-> !rc_osc_en && xtal_osc_en && xtal_select_state)
		else $error("bad active state");
	AST_HAND: assert property ($rose(xtal_active) |-> !low_freq_clock)
		else $error("handover not in low phase");
	AST_HIGH: assert property ($rose(low_freq_clock) |-> (low_freq_clock || !io_supply_ok)[*8])
		else $error("short high phase");
	AST_LOW: assert property ($fell(low_freq_clock) |-> (!low_freq_clock || !io_supply_ok)[*8])
		else $error("short low phase");
	AST_STICK: assert property (xtal_select_state && io_supply_ok |=> xtal_select_state)
		else $error("select lost");
	AST_SEL: assert property ($past(io_supply_ok, 5) && io_supply_ok
		&& crystal_select_wr && crystal_select_bit |=> xtal_select_state)
		else $error("select not taken");
	AST_BYP: assert property (xtal_bypass_en |-> pins_to_osc && xtal_select_state)
		else $error("bypass without pin handover");
	AST_BUSY: assert property ($fell(switch_busy) |-> xtal_active || !io_supply_ok)
		else $error("busy ended early");
endmodule

bind slow_clock_source_select lfclk_chk u_lfclk_chk (
	.clk                (clk),
	.nrst               (nrst),
	.crystal_select_wr  (crystal_select_wr),
	.crystal_select_bit (crystal_select_bit),
	.io_supply_ok       (io_supply_ok),
	.low_freq_clock     (low_freq_clock),
	.rc_osc_en          (rc_osc_en),
	.xtal_osc_en        (xtal_osc_en),
	.xtal_bypass_en     (xtal_bypass_en),
	.pins_to_osc        (pins_to_osc),
	.pin_pullup_en      (pin_pullup_en),
	.xtal_select_state  (xtal_select_state),
	.xtal_active        (xtal_active),
	.switch_busy        (switch_busy)
);

// [slow_clock_source_select_bench.sv]
// Self-checking bench for the slow clock source selector.
`timescale 1ns/1ps
module slow_clock_source_select_bench;
	logic clk = 1'b0, nrst = 1'b0, crystal_select_wr = 1'b0, crystal_select_bit = 1'b0;
	logic crystal_bypass_bit = 1'b0, io_supply_ok = 1'b1, rc_clk_in = 1'b0, crystal_in_pin;
	logic low_freq_clock, rc_osc_en, xtal_osc_en, xtal_bypass_en, pins_to_osc;
	logic pin_pullup_en, xtal_select_state, xtal_active, switch_busy;
	int miscompares = 0, checks_done = 0;
	slow_clock_source_select #(.XTAL_START(50), .PIN_SETTLE(2)) u_slow_clock_source_select (
		.clk                (clk),
		.nrst               (nrst),
		.crystal_select_wr  (crystal_select_wr),
		.crystal_select_bit (crystal_select_bit),
		.crystal_bypass_bit (crystal_bypass_bit),
		.io_supply_ok       (io_supply_ok),
		.rc_clk_in          (rc_clk_in),
		.crystal_in_pin     (crystal_in_pin),
		.low_freq_clock     (low_freq_clock),
		.rc_osc_en          (rc_osc_en),
		.xtal_osc_en        (xtal_osc_en),
		.xtal_bypass_en     (xtal_bypass_en),
		.pins_to_osc        (pins_to_osc),
		.pin_pullup_en      (pin_pullup_en),
		.xtal_select_state  (xtal_select_state),
		.xtal_active        (xtal_active),
		.switch_busy        (switch_busy)
	);
	xtal_model u_xtal_model (.osc_en(xtal_osc_en), .byp_en(xtal_bypass_en), .pin(crystal_in_pin));
	initial forever #25 clk = !clk;
	always #500 rc_clk_in = rc_osc_en ? !rc_clk_in : 1'b0;
	task automatic check(input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %b exp %b", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic b);
		@(posedge clk);
		crystal_select_wr <= 1'b1;
		crystal_select_bit <= b;
		@(posedge clk);
		crystal_select_wr <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic t_reset;
		repeat (20) @(negedge clk);
		check(rc_osc_en, 1'b1);
		check(xtal_osc_en, 1'b0);
		check(pin_pullup_en, 1'b1);
		check(xtal_active, 1'b0);
		check(switch_busy, 1'b0);
		// Five edges of filter and output latency, well inside an RC phase
		@(rc_clk_in);
		repeat (6) @(negedge clk);
		check(low_freq_clock, rc_clk_in);
		wr(1'b0);
		check(xtal_select_state, 1'b0);
		$display("reset test done");
	endtask
	task automatic t_switch(input logic byp);
		int n = 0;
		@(posedge clk);
		crystal_bypass_bit <= byp;
		wr(1'b1);
		check(pins_to_osc, 1'b1);
		check(xtal_bypass_en, byp);
		check(switch_busy, 1'b1);
		while (xtal_active !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check(low_freq_clock, 1'b0);
		check(switch_busy, 1'b0);
		check(rc_osc_en, 1'b0);
		check(xtal_osc_en, 1'b1);
		wr(1'b0);
		check(xtal_active, 1'b1);
		@(crystal_in_pin);
		repeat (6) @(negedge clk);
		check(low_freq_clock, crystal_in_pin);
		repeat (100) @(negedge clk);
		$display("switch test done");
	endtask
	task automatic t_supply;
		@(posedge clk);
		io_supply_ok <= 1'b0;
		repeat (10) @(negedge clk);
		check(rc_osc_en, 1'b1);
		check(xtal_active, 1'b0);
		check(pin_pullup_en, 1'b1);
		wr(1'b1);
		check(xtal_select_state, 1'b0);
		@(posedge clk);
		io_supply_ok <= 1'b1;
		repeat (40) @(posedge clk);
		$display("supply test done");
	endtask
	initial begin
		repeat (1200) @(posedge clk);
		miscompares++;
		conclude;
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_switch(1'b0);
		t_supply;
		t_switch(1'b1);
		t_supply;
		conclude;
	end
endmodule
